//--- hw/mera_pkg.sv
// constants and types shared by the energy and runtime accumulator
package mera_pkg;
	// ------------------------------------------------------------
	// register map (word offsets on the parameter port)
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_PARAM_RESET = 16'h0002;
	localparam logic [15:0] OFS_ENERGY_MS = 16'h051a;
	localparam logic [15:0] OFS_ENERGY_SEC = 16'h051b;
	localparam logic [15:0] OFS_ENERGY_WH = 16'h051c;
	localparam logic [15:0] OFS_ENERGY_KWH = 16'h051d;
	localparam logic [15:0] OFS_ENERGY_MWH = 16'h051e;
	localparam logic [15:0] OFS_RUN_MINUTES = 16'h051f;
	localparam logic [15:0] OFS_RUN_DAYS = 16'h0520;
	localparam logic [15:0] OFS_MOTOR_TYPE = 16'h0521;
	localparam logic [15:0] OFS_PM_CURRENT = 16'h0522;
	localparam logic [15:0] OFS_PM_POWER = 16'h0523;
	localparam logic [15:0] OFS_PM_SPEED = 16'h0524;
	localparam logic [15:0] OFS_STATUS = 16'h0530;

	// ------------------------------------------------------------
	// values, limits and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] CMD_CLEAR_ENERGY = 16'h0005;
	localparam logic [15:0] MINUTES_MAX = 16'h059f;
	localparam logic [15:0] DAYS_MAX = 16'hffff;
	localparam logic [15:0] TYPE_INDUCTION = 16'h0000;
	localparam logic [15:0] TYPE_SURFACE_MAGNET = 16'h0001;
	localparam logic [15:0] TYPE_INTERIOR_MAGNET = 16'h0002;
	localparam logic [15:0] PM_SPEED_RESET = 16'h07d0;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam int CURRENT_LIMIT_PCT = 120;
	localparam int CURRENT_DEFAULT_PCT = 90;
	localparam logic [16:0] WS_PER_WH = 17'h00e10;
	localparam logic [15:0] WH_PER_KWH = 16'h03e8;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam longint CLK_HZ = 50000000;
	localparam longint TICK_TIME_S = 1;
	localparam int TICK_CYCLES = int'(CLK_HZ * TICK_TIME_S);
	localparam int MIN_RUN_TIME_S = 60;
	localparam int SECONDS_PER_MINUTE = 60;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] megawattHour;
		logic [15:0] kilowattHour;
		logic [15:0] wattHour;
		logic [15:0] second;
		logic [15:0] millisecond;
	} mera_energy_s;

	typedef enum logic [1:0] {
		RUN_IDLE = 2'b00,
		RUN_ACTIVE = 2'b01,
		RUN_SAVE = 2'b11
	} mera_run_e;
endpackage : mera_pkg

//--- hw/mera_energy_accum.sv
// cascaded energy accumulator words
`timescale 1ns/1ps
module mera_energy_accum (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic secTick,
	input wire logic running,
	input wire logic [15:0] powerWatts,
	input wire logic clear,
	input wire logic load,
	input wire mera_pkg::mera_energy_s loadWords,
	output mera_pkg::mera_energy_s words
);
	// ------------------------------------------------------------
	// watt-second pair and the residue toward the next watt-hour
	// ------------------------------------------------------------
	logic [16:0] whResidue_reg;
	logic [31:0] wsPair;
	logic [31:0] kwhPair;
	logic whCarry;
	logic addNow;

	assign wsPair = {words.second, words.millisecond};
	assign kwhPair = {words.megawattHour, words.kilowattHour};
	assign addNow = running && secTick;
	// the residue drains one watt-hour per cycle, so a large reading
	// takes up to nineteen cycles to reach the upper words
	assign whCarry = whResidue_reg >= mera_pkg::WS_PER_WH;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			words.second <= mera_pkg::WORD_RESET;
			words.millisecond <= mera_pkg::WORD_RESET;
		end else if (ce) begin
			if (clear) begin
				words.second <= mera_pkg::WORD_RESET;
				words.millisecond <= mera_pkg::WORD_RESET;
			end else if (load) begin
				words.second <= loadWords.second;
				words.millisecond <= loadWords.millisecond;
			end else if (addNow) begin
				{words.second, words.millisecond} <= wsPair + {16'h0000, powerWatts};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			whResidue_reg <= 17'h00000;
		end else if (ce) begin
			if (clear || load) begin
				whResidue_reg <= 17'h00000;
			end else if (addNow) begin
				whResidue_reg <= whResidue_reg + {1'b0, powerWatts}
					- (whCarry ? mera_pkg::WS_PER_WH : 17'h00000);
			end else if (whCarry) begin
				whResidue_reg <= whResidue_reg - mera_pkg::WS_PER_WH;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			words.wattHour <= mera_pkg::WORD_RESET;
			words.kilowattHour <= mera_pkg::WORD_RESET;
			words.megawattHour <= mera_pkg::WORD_RESET;
		end else if (ce) begin
			if (clear) begin
				words.wattHour <= mera_pkg::WORD_RESET;
				words.kilowattHour <= mera_pkg::WORD_RESET;
				words.megawattHour <= mera_pkg::WORD_RESET;
			end else if (load) begin
				words.wattHour <= loadWords.wattHour;
				words.kilowattHour <= loadWords.kilowattHour;
				words.megawattHour <= loadWords.megawattHour;
			end else if (whCarry) begin
				if (words.wattHour >= mera_pkg::WH_PER_KWH - 16'h0001) begin
					words.wattHour <= mera_pkg::WORD_RESET;
					{words.megawattHour, words.kilowattHour} <= kwhPair + 32'h00000001;
				end else begin
					words.wattHour <= words.wattHour + 16'h0001;
				end
			end
		end
	end
endmodule : mera_energy_accum

//--- hw/mera_top.sv
// motor energy and runtime accumulator with motor rating registers
//
// Contract
// - Energy is added into the accumulator words from the moment the drive runs.
// - The energy words are handed to retained storage whenever the drive stops or loses power.
// - A later run adds onto the restored and kept total, never restarting from zero.
// - Writing 5 to the parameter reset command clears all five energy words.
// - Watt-seconds total is the second word times 65536 plus the millisecond word.
// - Kilowatt-hours total is the megawatt-hour word times 65536 plus the kilowatt-hour word.
// - The minutes register only holds 0 through 1439 and resets to 0.
// - The days register is a 16-bit count 0 through 65535 that resets to 0.
// - Writing zero to minutes and days clears the operation time and counting goes on from zero.
// - A run shorter than 60 seconds adds no operation time.
// - Motor type 0 is induction, 1 surface magnet, 2 interior magnet, default 0.
// - Magnet motor full-load current is limited to 0 to 120 percent of drive rated current.
// - Magnet motor rated power spans 0.00 to 655.35 kW and defaults to the drive rating.
// - Magnet motor rated speed spans 0 to 65535 rpm and resets to 2000.
`timescale 1ns/1ps
module mera_top #(
	parameter int TICK_CYCLES = mera_pkg::TICK_CYCLES,
	parameter logic [15:0] DRIVE_RATED_CURRENT = 16'h09c4,
	parameter logic [15:0] DRIVE_RATED_POWER = 16'h0226
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdData,
	input wire logic driveRunning,
	input wire logic [15:0] outputPowerWatts,
	input wire logic powerFailPin,
	input wire logic restoreValid,
	input wire mera_pkg::mera_energy_s restoreWords,
	output logic saveStrobe,
	output mera_pkg::mera_energy_s saveWords,
	output mera_pkg::mera_energy_s energyWords,
	output logic [15:0] motorTypeSelect,
	output logic [15:0] magnetMotorFullLoadCurrent,
	output logic [15:0] magnetMotorRatedPower,
	output logic [15:0] magnetMotorRatedSpeed
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	localparam logic [31:0] CURRENT_PRODUCT = 32'(DRIVE_RATED_CURRENT)
		* 32'(mera_pkg::CURRENT_LIMIT_PCT) / 32'd100;
	localparam logic [15:0] CURRENT_LIMIT = CURRENT_PRODUCT[15:0];
	localparam logic [31:0] CURRENT_DEF_PRODUCT = 32'(DRIVE_RATED_CURRENT)
		* 32'(mera_pkg::CURRENT_DEFAULT_PCT) / 32'd100;
	localparam logic [15:0] CURRENT_DEFAULT = CURRENT_DEF_PRODUCT[15:0];
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [5:0] SEC_LAST = 6'(mera_pkg::SECONDS_PER_MINUTE - 1);
	localparam logic [6:0] MIN_RUN = 7'(mera_pkg::MIN_RUN_TIME_S);

	// limit a written value to an upper bound
	function automatic logic [15:0] clampWord(input logic [15:0] value, input logic [15:0] limit);
		clampWord = (value > limit) ? limit : value;
	endfunction : clampWord

	// true for a write strobe aimed at one offset
	function automatic logic writeHit(input logic wr, input logic [15:0] addr,
		input logic [15:0] ofs);
		writeHit = wr && (addr == ofs);
	endfunction : writeHit

	// ------------------------------------------------------------
	// power-fail pin synchroniser
	// ------------------------------------------------------------
	logic powerFailMeta_reg;
	logic powerFailSync_reg;
	logic powerFailSeen_reg;
	logic powerFailRise;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			powerFailMeta_reg <= 1'b0;
			powerFailSync_reg <= 1'b0;
			powerFailSeen_reg <= 1'b0;
		end else if (ce) begin
			powerFailMeta_reg <= powerFailPin;
			powerFailSync_reg <= powerFailMeta_reg;
			powerFailSeen_reg <= powerFailSync_reg;
		end
	end

	assign powerFailRise = powerFailSync_reg && !powerFailSeen_reg;

	// ------------------------------------------------------------
	// one-second time base
	// ------------------------------------------------------------
	logic [TICK_W-1:0] tickCount_reg;
	logic secTick;

	assign secTick = (tickCount_reg == TICK_LAST);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tickCount_reg <= '0;
		end else if (ce) begin
			tickCount_reg <= secTick ? '0 : tickCount_reg + TICK_W'(1);
		end
	end

	// ------------------------------------------------------------
	// run tracking
	// ------------------------------------------------------------
	mera_pkg::mera_run_e runState_reg;
	mera_pkg::mera_run_e runState_next;
	logic running;

	// a power failure ends the run at once even if the run input lags
	assign running = (runState_reg == mera_pkg::RUN_ACTIVE) && !powerFailSync_reg;

	always_comb begin
		runState_next = runState_reg;
		case (runState_reg)
			mera_pkg::RUN_IDLE: begin
				if (driveRunning && !powerFailSync_reg) begin
					runState_next = mera_pkg::RUN_ACTIVE;
				end else if (powerFailRise) begin
					runState_next = mera_pkg::RUN_SAVE;
				end
			end
			mera_pkg::RUN_ACTIVE: begin
				if (!driveRunning || powerFailSync_reg) begin
					runState_next = mera_pkg::RUN_SAVE;
				end
			end
			mera_pkg::RUN_SAVE: begin
				runState_next = mera_pkg::RUN_IDLE;
			end
			default: begin
				runState_next = mera_pkg::RUN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			runState_reg <= mera_pkg::RUN_IDLE;
		end else if (ce) begin
			runState_reg <= runState_next;
		end
	end

	// ------------------------------------------------------------
	// register write decode
	// ------------------------------------------------------------
	logic energyClear;
	logic minutesWrite;
	logic daysWrite;

	assign energyClear = writeHit(regWr, regAddr, mera_pkg::OFS_PARAM_RESET)
		&& (regWrData == mera_pkg::CMD_CLEAR_ENERGY);
	assign minutesWrite = writeHit(regWr, regAddr, mera_pkg::OFS_RUN_MINUTES);
	assign daysWrite = writeHit(regWr, regAddr, mera_pkg::OFS_RUN_DAYS);

	// ------------------------------------------------------------
	// energy words
	// ------------------------------------------------------------
	logic restoreDone_reg;
	logic restoreLoad;

	// retained total is taken once, before any run can add to it
	assign restoreLoad = restoreValid && !restoreDone_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			restoreDone_reg <= 1'b0;
		end else if (ce) begin
			if (restoreLoad || running) begin
				restoreDone_reg <= 1'b1;
			end
		end
	end

	mera_energy_accum u_energy (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.secTick(secTick),
		.running(running),
		.powerWatts(outputPowerWatts),
		.clear(energyClear),
		.load(restoreLoad),
		.loadWords(restoreWords),
		.words(energyWords)
	);

	// the save copy is taken when the run ends, so later reads of the
	// live words never disturb what storage receives
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			saveStrobe <= 1'b0;
			saveWords <= '0;
		end else if (ce) begin
			saveStrobe <= (runState_reg == mera_pkg::RUN_SAVE);
			if (runState_reg == mera_pkg::RUN_SAVE) begin
				saveWords <= energyWords;
			end
		end
	end

	// ------------------------------------------------------------
	// operation time
	// ------------------------------------------------------------
	logic [6:0] runSeconds_reg;
	logic [5:0] secInMinute_reg;
	logic minuteTick;
	logic [15:0] runtimeMinutes_reg;
	logic [15:0] runtimeDays_reg;

	// a minute counts only once the run itself has lasted the minimum
	assign minuteTick = running && secTick && (secInMinute_reg == SEC_LAST)
		&& (runSeconds_reg >= MIN_RUN - 7'd1);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			runSeconds_reg <= 7'd0;
			secInMinute_reg <= 6'd0;
		end else if (ce) begin
			if (!running) begin
				runSeconds_reg <= 7'd0;
				secInMinute_reg <= 6'd0;
			end else if (secTick) begin
				if (runSeconds_reg < MIN_RUN) begin
					runSeconds_reg <= runSeconds_reg + 7'd1;
				end
				secInMinute_reg <= (secInMinute_reg == SEC_LAST) ? 6'd0
					: secInMinute_reg + 6'd1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			runtimeMinutes_reg <= mera_pkg::WORD_RESET;
		end else if (ce) begin
			if (minutesWrite) begin
				runtimeMinutes_reg <= clampWord(regWrData, mera_pkg::MINUTES_MAX);
			end else if (minuteTick) begin
				runtimeMinutes_reg <= (runtimeMinutes_reg >= mera_pkg::MINUTES_MAX)
					? mera_pkg::WORD_RESET : runtimeMinutes_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			runtimeDays_reg <= mera_pkg::WORD_RESET;
		end else if (ce) begin
			if (daysWrite) begin
				runtimeDays_reg <= regWrData;
			end else if (minuteTick && !minutesWrite
				&& (runtimeMinutes_reg >= mera_pkg::MINUTES_MAX)
				&& (runtimeDays_reg != mera_pkg::DAYS_MAX)) begin
				runtimeDays_reg <= runtimeDays_reg + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// motor rating registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			motorTypeSelect <= mera_pkg::TYPE_INDUCTION;
		end else if (ce) begin
			// codes beyond the interior magnet type are refused, old value kept
			if (writeHit(regWr, regAddr, mera_pkg::OFS_MOTOR_TYPE)
				&& (regWrData <= mera_pkg::TYPE_INTERIOR_MAGNET)) begin
				motorTypeSelect <= regWrData;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			magnetMotorFullLoadCurrent <= CURRENT_DEFAULT;
		end else if (ce) begin
			if (writeHit(regWr, regAddr, mera_pkg::OFS_PM_CURRENT)) begin
				magnetMotorFullLoadCurrent <= clampWord(regWrData, CURRENT_LIMIT);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			magnetMotorRatedPower <= DRIVE_RATED_POWER;
		end else if (ce) begin
			if (writeHit(regWr, regAddr, mera_pkg::OFS_PM_POWER)) begin
				magnetMotorRatedPower <= regWrData;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			magnetMotorRatedSpeed <= mera_pkg::PM_SPEED_RESET;
		end else if (ce) begin
			if (writeHit(regWr, regAddr, mera_pkg::OFS_PM_SPEED)) begin
				magnetMotorRatedSpeed <= regWrData;
			end
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	logic [15:0] readMux;
	logic [15:0] statusWord;

	assign statusWord = {12'h000, restoreDone_reg, powerFailSync_reg, runState_reg};

	always_comb begin
		case (regAddr)
			mera_pkg::OFS_ENERGY_MS: readMux = energyWords.millisecond;
			mera_pkg::OFS_ENERGY_SEC: readMux = energyWords.second;
			mera_pkg::OFS_ENERGY_WH: readMux = energyWords.wattHour;
			mera_pkg::OFS_ENERGY_KWH: readMux = energyWords.kilowattHour;
			mera_pkg::OFS_ENERGY_MWH: readMux = energyWords.megawattHour;
			mera_pkg::OFS_RUN_MINUTES: readMux = runtimeMinutes_reg;
			mera_pkg::OFS_RUN_DAYS: readMux = runtimeDays_reg;
			mera_pkg::OFS_MOTOR_TYPE: readMux = motorTypeSelect;
			mera_pkg::OFS_PM_CURRENT: readMux = magnetMotorFullLoadCurrent;
			mera_pkg::OFS_PM_POWER: readMux = magnetMotorRatedPower;
			mera_pkg::OFS_PM_SPEED: readMux = magnetMotorRatedSpeed;
			mera_pkg::OFS_STATUS: readMux = statusWord;
			default: readMux = 16'h0000;
		endcase
	end

	// data stand for the single cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regRdData <= 16'h0000;
		end else if (ce) begin
			regRdData <= regRd ? readMux : 16'h0000;
		end
	end
endmodule : mera_top

//--- bench/mera_drive_model.sv
// drive side model: run status, output power, power loss pin and retained storage
`timescale 1ns/1ps
module mera_drive_model #(
	parameter logic [79:0] RESTORE_WORDS = 80'h0
) (
	input wire logic clk,
	input wire logic runReq,
	input wire logic [15:0] wattsReq,
	input wire logic failReq,
	input wire logic restoreReq,
	output logic driveRunning,
	output logic [15:0] outputPowerWatts,
	output logic powerFailPin,
	output logic restoreValid,
	output mera_pkg::mera_energy_s restoreWords
);
	initial begin
		driveRunning = 1'b0;
		outputPowerWatts = 16'h0000;
		powerFailPin = 1'b0;
		restoreValid = 1'b0;
		restoreWords = '0;
	end
	always @(posedge clk) begin
		driveRunning <= runReq;
		outputPowerWatts <= runReq ? wattsReq : 16'h0000;
		powerFailPin <= failReq;
		restoreValid <= restoreReq;
		// stale words toggle so a design that ignores restoreValid cannot match by luck
		restoreWords <= restoreReq ? RESTORE_WORDS : ~restoreWords;
	end
endmodule : mera_drive_model

//--- bench/mera_top_asserts.sv
// port checker for the energy and runtime accumulator
`timescale 1ns/1ps
module mera_top_asserts #(
	parameter logic [15:0] DRIVE_RATED_CURRENT = 16'h09c4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdData,
	input wire logic driveRunning,
	input wire logic powerFailPin,
	input wire logic restoreValid,
	input wire logic saveStrobe,
	input wire mera_pkg::mera_energy_s saveWords,
	input wire mera_pkg::mera_energy_s energyWords,
	input wire logic [15:0] motorTypeSelect,
	input wire logic [15:0] magnetMotorFullLoadCurrent,
	input wire logic [15:0] magnetMotorRatedSpeed
);
	localparam logic [15:0] CUR_MAX = 16'(32'(DRIVE_RATED_CURRENT) * 120 / 100);
	logic [31:0] wsCount;
	assign wsCount = {energyWords.second, energyWords.millisecond};
	// frozen cycles (ce low) are skipped so held values never look like events
	default clocking cb @(posedge clk iff ce); endclocking
	default disable iff (!rst_n);
	sequence stopRun; $fell(driveRunning) && !powerFailPin; endsequence
	sequence failRun; $rose(powerFailPin) && driveRunning; endsequence
	sequence saveSoon; ##[1:3] saveStrobe; endsequence
	a_save_on_stop: assert property (stopRun |-> saveSoon)
		else $error("no save after the drive stopped");
	a_save_on_fail: assert property (failRun |-> ##[2:6] saveStrobe)
		else $error("no save after power loss");
	a_save_single: assert property (saveStrobe |=> !saveStrobe)
		else $error("save strobe longer than one cycle");
	a_save_copy: assert property (saveStrobe |-> saveWords == $past(energyWords))
		else $error("saved words differ from the live words");
	a_energy_grows: assert property (!restoreValid && !(regWr &&
		regAddr == mera_pkg::OFS_PARAM_RESET) |=> wsCount >= $past(wsCount))
		else $error("watt-second count went down");
	a_energy_clear: assert property (regWr && regAddr == mera_pkg::OFS_PARAM_RESET &&
		regWrData == mera_pkg::CMD_CLEAR_ENERGY |=> energyWords == '0)
		else $error("energy words not cleared");
	a_minutes_range: assert property (regRd && regAddr == mera_pkg::OFS_RUN_MINUTES
		|=> regRdData <= mera_pkg::MINUTES_MAX)
		else $error("minutes above range");
	a_type_legal: assert property (motorTypeSelect <= mera_pkg::TYPE_INTERIOR_MAGNET)
		else $error("motor type out of range");
	a_type_write: assert property (regWr && regAddr == mera_pkg::OFS_MOTOR_TYPE &&
		regWrData <= mera_pkg::TYPE_INTERIOR_MAGNET |=> motorTypeSelect == $past(regWrData))
		else $error("motor type write lost");
	a_current_limit: assert property (magnetMotorFullLoadCurrent <= CUR_MAX)
		else $error("full-load current above limit");
	a_reset_values: assert property ($rose(rst_n) |-> energyWords == '0 &&
		magnetMotorRatedSpeed == mera_pkg::PM_SPEED_RESET && motorTypeSelect == 16'h0000)
		else $error("wrong value after reset");
	a_read_idle: assert property (!regRd |=> regRdData == 16'h0000)
		else $error("read data outside read cycle");
endmodule : mera_top_asserts
bind mera_top mera_top_asserts #(.DRIVE_RATED_CURRENT(DRIVE_RATED_CURRENT)) chk (
	.clk(clk), .rst_n(rst_n), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .driveRunning(driveRunning),
	.powerFailPin(powerFailPin), .restoreValid(restoreValid), .saveStrobe(saveStrobe),
	.saveWords(saveWords), .energyWords(energyWords), .motorTypeSelect(motorTypeSelect),
	.magnetMotorFullLoadCurrent(magnetMotorFullLoadCurrent),
	.magnetMotorRatedSpeed(magnetMotorRatedSpeed));

//--- bench/mera_top_bench.sv
// self-checking bench for the energy and runtime accumulator
`timescale 1ns/1ps
module mera_top_bench;
	localparam int TICKS = 40;
	localparam logic [15:0] CUR = 16'h09c4;
	localparam logic [15:0] POW = 16'h0226;
	localparam logic [79:0] RESTORE = 80'h0000_0002_0005_0000_fff0;
	logic clk = 1'b0;
	logic ce = 1'b1;
	logic rstN = 1'b0;
	logic regWr = 1'b0, regRd = 1'b0, runReq = 1'b0, failReq = 1'b0, restoreReq = 1'b0;
	logic [15:0] regAddr = '0, regWrData = '0, wattsReq = '0, regRdData, outputPowerWatts;
	logic [15:0] motorType, fullCur, ratedPow, ratedSpd;
	logic driveRunning, powerFailPin, restoreValid, saveStrobe;
	mera_pkg::mera_energy_s restoreWords, saveWords, energyWords;
	int fail_count = 0;
	int checked = 0;
	int phase = 0;
	always #10 clk = ~clk;
	// mirrors the one-second tick so runs start halfway between ticks
	always @(posedge clk) if (ce) phase <= rstN ? (phase + 1) % TICKS : 0;
	mera_top #(.TICK_CYCLES(TICKS), .DRIVE_RATED_CURRENT(CUR), .DRIVE_RATED_POWER(POW)) dut (
		.clk(clk), .rst_n(rstN), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .driveRunning(driveRunning),
		.outputPowerWatts(outputPowerWatts), .powerFailPin(powerFailPin),
		.restoreValid(restoreValid), .restoreWords(restoreWords), .saveStrobe(saveStrobe),
		.saveWords(saveWords), .energyWords(energyWords), .motorTypeSelect(motorType),
		.magnetMotorFullLoadCurrent(fullCur), .magnetMotorRatedPower(ratedPow),
		.magnetMotorRatedSpeed(ratedSpd));
	mera_drive_model #(.RESTORE_WORDS(RESTORE)) partner (
		.clk(clk), .runReq(runReq), .wattsReq(wattsReq), .failReq(failReq),
		.restoreReq(restoreReq), .driveRunning(driveRunning),
		.outputPowerWatts(outputPowerWatts), .powerFailPin(powerFailPin),
		.restoreValid(restoreValid), .restoreWords(restoreWords));
	// ------------------------------------------------------------
	// access and comparison tasks
	// ------------------------------------------------------------
	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		check(80'(regRdData), 80'(e));
	endtask : rd
	// runs for whole seconds, then stops by run status or by power loss
	task automatic run(input int secs, input logic [15:0] w, input logic byFail);
		wait (phase == 20);
		@(posedge clk);
		runReq <= 1'b1;
		wattsReq <= w;
		repeat (secs * TICKS) @(posedge clk);
		if (byFail) begin
			failReq <= 1'b1;
		end else begin
			runReq <= 1'b0;
		end
		repeat (10) @(posedge clk);
		runReq <= 1'b0;
		repeat (40) @(posedge clk);
		failReq <= 1'b0;
		#1;
	endtask : run
	task automatic finish_test;
		if (fail_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rstN <= 1'b1;
		restoreReq <= 1'b1;
		@(posedge clk);
		restoreReq <= 1'b0;
		rd(mera_pkg::OFS_MOTOR_TYPE, 16'h0000);
		rd(mera_pkg::OFS_PM_CURRENT, 16'(32'(CUR) * 90 / 100));
		rd(mera_pkg::OFS_PM_POWER, POW);
		rd(mera_pkg::OFS_PM_SPEED, 16'h07d0);
		rd(mera_pkg::OFS_RUN_MINUTES, 16'h0000);
		rd(mera_pkg::OFS_RUN_DAYS, 16'h0000);
		rd(16'h0600, 16'h0000);
		rd(mera_pkg::OFS_STATUS, 16'h0008);
		check(energyWords, RESTORE);
		for (int t = 0; t < 4; t++) begin
			wr(mera_pkg::OFS_MOTOR_TYPE, 16'(t));
			rd(mera_pkg::OFS_MOTOR_TYPE, (t < 3) ? 16'(t) : 16'h0002);
		end
		wr(mera_pkg::OFS_PM_CURRENT, 16'hffff);
		rd(mera_pkg::OFS_PM_CURRENT, 16'(32'(CUR) * 120 / 100));
		wr(mera_pkg::OFS_PM_POWER, 16'hffff);
		rd(mera_pkg::OFS_PM_POWER, 16'hffff);
		wr(mera_pkg::OFS_PM_SPEED, 16'hffff);
		rd(mera_pkg::OFS_PM_SPEED, 16'hffff);
		// a write while the clock enable is low must leave the register alone
		@(posedge clk);
		ce <= 1'b0;
		wr(mera_pkg::OFS_PM_SPEED, 16'h1234);
		ce <= 1'b1;
		rd(mera_pkg::OFS_PM_SPEED, 16'hffff);
		wr(mera_pkg::OFS_ENERGY_MS, 16'h1234);
		rd(mera_pkg::OFS_ENERGY_MS, 16'hfff0);
		wr(mera_pkg::OFS_RUN_MINUTES, 16'h05dc);
		rd(mera_pkg::OFS_RUN_MINUTES, 16'h059f);
		run(60, 16'hea60, 1'b0);
		check(energyWords, 80'h0000_0003_0005_0037_ee70);
		check(saveWords, 80'h0000_0003_0005_0037_ee70);
		rd(mera_pkg::OFS_ENERGY_SEC, 16'h0037);
		rd(mera_pkg::OFS_RUN_MINUTES, 16'h0000);
		rd(mera_pkg::OFS_RUN_DAYS, 16'h0001);
		run(10, 16'h0064, 1'b1);
		check(saveWords, 80'h0000_0003_0005_0037_f258);
		rd(mera_pkg::OFS_RUN_MINUTES, 16'h0000);
		wr(mera_pkg::OFS_RUN_DAYS, 16'hffff);
		wr(mera_pkg::OFS_RUN_MINUTES, 16'h059f);
		run(60, 16'h0000, 1'b0);
		rd(mera_pkg::OFS_RUN_MINUTES, 16'h0000);
		rd(mera_pkg::OFS_RUN_DAYS, 16'hffff);
		wr(mera_pkg::OFS_PARAM_RESET, 16'h0004);
		#1;
		check(energyWords, 80'h0000_0003_0005_0037_f258);
		wr(mera_pkg::OFS_PARAM_RESET, mera_pkg::CMD_CLEAR_ENERGY);
		rd(mera_pkg::OFS_ENERGY_KWH, 16'h0000);
		wr(mera_pkg::OFS_RUN_MINUTES, 16'h0000);
		wr(mera_pkg::OFS_RUN_DAYS, 16'h0000);
		rd(mera_pkg::OFS_RUN_DAYS, 16'h0000);
		run(60, 16'h0064, 1'b0);
		rd(mera_pkg::OFS_RUN_MINUTES, 16'h0001);
		check(energyWords, 80'h0000_0000_0001_0000_1770);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		finish_test();
	end
endmodule : mera_top_bench
